/* gtc_pkg.sv */
// Constants, types and shared decoding for the general-purpose timer block.
// Assumes a single 125 MHz system clock and a 12-bit configuration-region offset.
package gtc_pkg;

	// Register offsets within the configuration region
	localparam logic [11:0] GTC_T1_COUNT_OFS = 12'hc7c;
	localparam logic [11:0] GTC_T1_CMPA_OFS = 12'hc7e;
	localparam logic [11:0] GTC_T1_CMPB_OFS = 12'hc80;
	localparam logic [11:0] GTC_T2_CTRL_OFS = 12'hc82;

	// Timer 2 control field positions
	localparam int GTC_T2_RUN_BIT = 15;
	localparam int GTC_T2_PERMIT_BIT = 14;
	localparam int GTC_T2_IRQ_BIT = 13;
	localparam int GTC_T2_FLAG_BIT = 5;
	localparam int GTC_T2_CONT_BIT = 0;

	// Reset values and count limits
	localparam logic [15:0] GTC_RESET_VALUE = 16'h0000;
	localparam logic [15:0] GTC_ALL_ONES = 16'hffff;
	localparam logic [15:0] GTC_ONE = 16'h0001;

	// Clock and prescale timing
	localparam int GTC_CLK_PERIOD_NS = 8;
	localparam int GTC_PRESCALE_CYCLES = 4;

	// Prescale phases, Gray coded
	typedef enum logic [1:0] {
		GTC_PH0 = 2'b00,
		GTC_PH1 = 2'b01,
		GTC_PH2 = 2'b11,
		GTC_PH3 = 2'b10
	} gtc_phase_t;

	// Terminal value: zero compare means count to all ones
	function automatic logic [15:0] gtc_limit(input logic [15:0] cmp);
		gtc_limit = (cmp == GTC_RESET_VALUE) ? GTC_ALL_ONES : cmp;
	endfunction

endpackage

/* gtc_timer2.sv */
// Timer 2 single-compare counter, used as the prescaler for timer 1.
// Assumes the parent supplies the divide-by-four tick and owns the control register.
module gtc_timer2
	import gtc_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// Control
	input wire logic tick_i,
	input wire logic run_i,
	input wire logic [15:0] compare_value_i,
	// Status
	output logic terminal_o,
	output logic [15:0] count_value_o
);

	logic [15:0] count_value_reg;
	logic [15:0] count_value_next;
	logic [15:0] count_inc;
	logic step;
	logic hit;

	// Counting halts while run is low, holding the count
	assign step = ce_i & run_i & tick_i;
	assign count_inc = count_value_reg + GTC_ONE;
	assign hit = step & (count_inc == gtc_limit(compare_value_i));
	assign count_value_next = hit ? GTC_RESET_VALUE : count_inc;
	assign terminal_o = hit;
	assign count_value_o = count_value_reg;

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			count_value_reg <= GTC_RESET_VALUE;
		end else if (step) begin
			count_value_reg <= count_value_next;
		end
	end

endmodule

/* gtc_timer.sv */
// Timer 1 count and compare logic with the timer 2 control register.
// Assumes register accesses arrive as single-cycle strobes on the system clock;
// the external input pin is asynchronous and is synchronised here.
//
// Summary of operation
// RQ1: Internal source advances count every fourth clock.
// RQ2: Prescale source advances on timer 2 terminal.
// RQ3: External source counts pin rising edges, quarter-rate max.
// RQ4: Count readable anytime, cleared at terminal value.
// RQ5: Count writes always accepted, counting resumes from it.
// RQ6: Each increment compared against compare register in use.
// RQ7: Two 16-bit compare registers, A and B.
// RQ8: Zero compare counts up to all ones.
// RQ9: Nonzero compare counts to programmed value.
// RQ10: Timer 2 run bit gates counting.
// RQ11: Clearing run freezes count, status unchanged.
// RQ12: Run bit changes only with permit set.
// RQ13: Noncontinuous timer 2 clears run at end.
// RQ14: Control holds irq allow, flag, continuous select.
// RQ15: Alternate mode alternates A then B.
// RQ16: In-use flag shows B, cleared on hardware stop.
// RQ17: Noncontinuous halts and clears run; continuous restarts.
// RQ18: Permit bit always reads zero.
module gtc_timer
	import gtc_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// Register access
	input wire logic [11:0] memory_mapped_config_region_addr_i,
	input wire logic memory_mapped_config_region_wr_i,
	input wire logic memory_mapped_config_region_rd_i,
	input wire logic [15:0] memory_mapped_config_region_wdata_i,
	output logic [15:0] memory_mapped_config_region_rdata_o,
	// Timer 1 control
	input wire logic timer_run_i,
	input wire logic external_source_select_i,
	input wire logic prescale_source_select_i,
	input wire logic alternate_compare_select_i,
	input wire logic continuous_select_i,
	// Timer 2 compare value
	input wire logic [15:0] timer2_compare_value_i,
	// External pin
	input wire logic timer1_input_pin_i,
	// Status
	output logic compare_in_use_flag_o,
	output logic terminal_reached_o,
	output logic timer_run_clear_o,
	output logic timer2_terminal_o,
	output logic irq_allow_o
);

	// Prescale phase
	gtc_phase_t phase_reg;
	gtc_phase_t phase_next;
	logic quarter_tick;

	// Pin synchroniser and edge detect
	logic pin_meta_reg;
	logic pin_sync_reg;
	logic pin_prev_reg;
	logic pin_rise;

	// Timer 1 registers
	logic [15:0] count_value_reg;
	logic [15:0] count_value_next;
	logic [15:0] compare_a_value_reg;
	logic [15:0] compare_b_value_reg;
	logic compare_in_use_flag_reg;
	logic compare_in_use_flag_next;
	logic halted_reg;
	logic terminal_reg;
	logic run_clear_reg;

	// Timer 2 control register fields
	logic t2_run_reg;
	logic t2_run_next;
	logic irq_allow_reg;
	logic terminal_reached_flag_reg;
	logic terminal_reached_flag_next;
	logic continuous_select_reg;
	logic t2_term;
	logic t2_term_reg;

	// Bus decode
	logic wr_count;
	logic wr_cmpa;
	logic wr_cmpb;
	logic wr_t2ctrl;
	logic [15:0] t2_ctrl_view;
	logic [15:0] read_mux;
	logic [15:0] rdata_reg;

	// Timer 1 datapath
	logic run_eff;
	logic source_tick;
	logic step;
	logic [15:0] count_inc;
	logic [15:0] limit_raw;
	logic hit;
	logic seq_end;

	// Divide-by-four phase walk
	always_comb begin
		case (phase_reg)
			GTC_PH0: phase_next = GTC_PH1;
			GTC_PH1: phase_next = GTC_PH2;
			GTC_PH2: phase_next = GTC_PH3;
			GTC_PH3: phase_next = GTC_PH0;
			default: phase_next = GTC_PH0;
		endcase
	end

	assign quarter_tick = (phase_reg == GTC_PH3); // [RQ1]

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			phase_reg <= GTC_PH0;
		end else if (ce_i) begin
			phase_reg <= phase_next;
		end
	end

	// Two-stage synchroniser, then edge detector on the second stage
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_meta_reg <= 1'b0;
			pin_sync_reg <= 1'b0;
			pin_prev_reg <= 1'b0;
		end else if (ce_i) begin
			pin_meta_reg <= timer1_input_pin_i;
			pin_sync_reg <= pin_meta_reg;
			pin_prev_reg <= pin_sync_reg;
		end
	end

	assign pin_rise = pin_sync_reg & ~pin_prev_reg; // [RQ3]

	// Register decode
	assign wr_count = memory_mapped_config_region_wr_i & (memory_mapped_config_region_addr_i == GTC_T1_COUNT_OFS);
	assign wr_cmpa = memory_mapped_config_region_wr_i & (memory_mapped_config_region_addr_i == GTC_T1_CMPA_OFS);
	assign wr_cmpb = memory_mapped_config_region_wr_i & (memory_mapped_config_region_addr_i == GTC_T1_CMPB_OFS);
	assign wr_t2ctrl = memory_mapped_config_region_wr_i & (memory_mapped_config_region_addr_i == GTC_T2_CTRL_OFS);

	// Timer 2 counter
	gtc_timer2 u_timer2 (
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.ce_i(ce_i),
		.tick_i(quarter_tick),
		.run_i(t2_run_reg), // [RQ10] [RQ11]
		.compare_value_i(timer2_compare_value_i),
		.terminal_o(t2_term),
		.count_value_o()
	);

	// Source selection
	assign source_tick = external_source_select_i ? pin_rise : // [RQ3]
		(prescale_source_select_i ? t2_term : quarter_tick); // [RQ1] [RQ2]

	// Hardware stop holds until software drops run
	assign run_eff = timer_run_i & ~halted_reg;
	assign step = ce_i & run_eff & source_tick & ~wr_count;
	assign count_inc = count_value_reg + GTC_ONE;
	assign limit_raw = compare_in_use_flag_reg ? compare_b_value_reg : compare_a_value_reg; // [RQ6] [RQ15]
	assign hit = step & (count_inc == gtc_limit(limit_raw)); // [RQ6] [RQ8] [RQ9]
	assign seq_end = hit & ~continuous_select_i & (~alternate_compare_select_i | compare_in_use_flag_reg); // [RQ17]

	// Count update: a write wins over the increment
	assign count_value_next = wr_count ? memory_mapped_config_region_wdata_i : // [RQ5]
		(hit ? GTC_RESET_VALUE : count_inc); // [RQ4] [RQ17]

	// In-use flag walks A to B only in alternate mode
	assign compare_in_use_flag_next = seq_end ? 1'b0 : // [RQ16]
		(~alternate_compare_select_i ? 1'b0 : // [RQ15]
		(hit ? ~compare_in_use_flag_reg : compare_in_use_flag_reg)); // [RQ15] [RQ16]

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			count_value_reg <= GTC_RESET_VALUE;
		end else if (ce_i && (wr_count || step)) begin
			count_value_reg <= count_value_next; // [RQ4] [RQ5]
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			compare_a_value_reg <= GTC_RESET_VALUE;
			compare_b_value_reg <= GTC_RESET_VALUE;
		end else if (ce_i) begin
			if (wr_cmpa) begin
				compare_a_value_reg <= memory_mapped_config_region_wdata_i; // [RQ7]
			end
			if (wr_cmpb) begin
				compare_b_value_reg <= memory_mapped_config_region_wdata_i; // [RQ7]
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			compare_in_use_flag_reg <= 1'b0;
			halted_reg <= 1'b0;
			terminal_reg <= 1'b0;
			run_clear_reg <= 1'b0;
		end else if (ce_i) begin
			compare_in_use_flag_reg <= compare_in_use_flag_next;
			halted_reg <= seq_end | (halted_reg & timer_run_i); // [RQ17]
			terminal_reg <= hit;
			run_clear_reg <= seq_end; // [RQ17]
		end
	end

	// Timer 2 control: run changes only with permit; write wins over hardware clear
	assign t2_run_next = (wr_t2ctrl && memory_mapped_config_region_wdata_i[GTC_T2_PERMIT_BIT]) ? memory_mapped_config_region_wdata_i[GTC_T2_RUN_BIT] : // [RQ12]
		((t2_term && !continuous_select_reg) ? 1'b0 : t2_run_reg); // [RQ13]

	// Flag: hardware set wins; software can only clear by writing zero
	assign terminal_reached_flag_next = t2_term | // [RQ14]
		(terminal_reached_flag_reg & ~(wr_t2ctrl & ~memory_mapped_config_region_wdata_i[GTC_T2_FLAG_BIT]));

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			t2_run_reg <= 1'b0;
			irq_allow_reg <= 1'b0;
			terminal_reached_flag_reg <= 1'b0;
			continuous_select_reg <= 1'b0;
			t2_term_reg <= 1'b0;
		end else if (ce_i) begin
			t2_run_reg <= t2_run_next; // [RQ10] [RQ12] [RQ13]
			terminal_reached_flag_reg <= terminal_reached_flag_next;
			t2_term_reg <= t2_term;
			if (wr_t2ctrl) begin
				irq_allow_reg <= memory_mapped_config_region_wdata_i[GTC_T2_IRQ_BIT]; // [RQ14]
				continuous_select_reg <= memory_mapped_config_region_wdata_i[GTC_T2_CONT_BIT]; // [RQ14]
			end
		end
	end

	// Control view: permit and reserved bits read zero
	assign t2_ctrl_view = {t2_run_reg, 1'b0, irq_allow_reg, 7'h00, // [RQ18]
		terminal_reached_flag_reg, 4'h0, continuous_select_reg}; // [RQ14]

	// Read selection; unmapped offsets read zero
	assign read_mux = (memory_mapped_config_region_addr_i == GTC_T1_COUNT_OFS) ? count_value_reg : // [RQ4]
		(memory_mapped_config_region_addr_i == GTC_T1_CMPA_OFS) ? compare_a_value_reg :
		(memory_mapped_config_region_addr_i == GTC_T1_CMPB_OFS) ? compare_b_value_reg :
		(memory_mapped_config_region_addr_i == GTC_T2_CTRL_OFS) ? t2_ctrl_view : GTC_RESET_VALUE;

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_reg <= GTC_RESET_VALUE;
		end else if (ce_i && memory_mapped_config_region_rd_i) begin
			rdata_reg <= read_mux;
		end
	end

	// Outputs
	assign memory_mapped_config_region_rdata_o = rdata_reg;
	assign compare_in_use_flag_o = compare_in_use_flag_reg;
	assign terminal_reached_o = terminal_reg;
	assign timer_run_clear_o = run_clear_reg;
	assign timer2_terminal_o = t2_term_reg;
	assign irq_allow_o = irq_allow_reg;

endmodule

/* gtc_timer_monitor.sv */
// Port checker for the timer block.
// Assumes a bind to gtc_timer; count steps never come closer than four cycles.
module gtc_timer_monitor
	import gtc_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// Register access
	input wire logic [11:0] memory_mapped_config_region_addr_i,
	input wire logic memory_mapped_config_region_wr_i,
	input wire logic memory_mapped_config_region_rd_i,
	input wire logic [15:0] memory_mapped_config_region_wdata_i,
	input wire logic [15:0] memory_mapped_config_region_rdata_o,
	// Control and status
	input wire logic timer_run_i,
	input wire logic alternate_compare_select_i,
	input wire logic compare_in_use_flag_o,
	input wire logic terminal_reached_o,
	input wire logic timer_run_clear_o,
	input wire logic timer2_terminal_o,
	input wire logic irq_allow_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);
	a_term_spacing: assert property (terminal_reached_o |=> !terminal_reached_o [*3])
		else $error("terminal pulses too close");
	a_t2_spacing: assert property (timer2_terminal_o |=> !timer2_terminal_o [*3])
		else $error("timer 2 pulses too close");
	a_stop_at_hit: assert property (timer_run_clear_o |-> terminal_reached_o && !compare_in_use_flag_o)
		else $error("stop without hit or in-use set");
	a_stop_pulse: assert property (timer_run_clear_o |=> !timer_run_clear_o)
		else $error("stop pulse too long");
	a_single_uses_a: assert property (ce_i && !alternate_compare_select_i |=> !compare_in_use_flag_o)
		else $error("compare B in use in single mode");
	a_swap_on_hit: assert property ($changed(compare_in_use_flag_o) && $past(alternate_compare_select_i)
		|-> terminal_reached_o)
		else $error("compare swap without hit");
	a_idle_no_term: assert property (!timer_run_i |=> !terminal_reached_o)
		else $error("terminal while disabled");
	a_irq_write: assert property (ce_i && memory_mapped_config_region_wr_i && memory_mapped_config_region_addr_i == GTC_T2_CTRL_OFS
		|=> irq_allow_o == $past(memory_mapped_config_region_wdata_i[13]))
		else $error("irq allow not written");
	a_rdata_holds: assert property (!(ce_i && memory_mapped_config_region_rd_i) |=> $stable(memory_mapped_config_region_rdata_o))
		else $error("read data changed without read");
endmodule

bind gtc_timer gtc_timer_monitor u_monitor (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
	.memory_mapped_config_region_addr_i(memory_mapped_config_region_addr_i), .memory_mapped_config_region_wr_i(memory_mapped_config_region_wr_i), .memory_mapped_config_region_rd_i(memory_mapped_config_region_rd_i), .memory_mapped_config_region_wdata_i(memory_mapped_config_region_wdata_i),
	.memory_mapped_config_region_rdata_o(memory_mapped_config_region_rdata_o), .timer_run_i(timer_run_i), .alternate_compare_select_i(alternate_compare_select_i),
	.compare_in_use_flag_o(compare_in_use_flag_o), .terminal_reached_o(terminal_reached_o),
	.timer_run_clear_o(timer_run_clear_o), .timer2_terminal_o(timer2_terminal_o), .irq_allow_o(irq_allow_o));

/* test_gtc_timer.sv */
// Bench for gtc_timer: registers, count sources, compare modes.
// Assumes gtc_timer_monitor is bound to the design by its own file.
module test_gtc_timer
	import gtc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys_i = 0, arst_n_i = 0, ce = 1, wr_s = 0, rd_s = 0, run = 0, ext = 0, psc = 0, alt = 0, cont = 0;
	logic pin = 0, flag, term, rclr, t2term, irq, rd_seen = 0;
	logic [11:0] addr = 12'h000;
	logic [15:0] wdata = 16'h0000, t2cmp = 16'h0000, rdata, lfsr = 16'h0038, v;
	logic [1:0] pdiv = 2'b00;
	int miscompares = 0, checks_done = 0, cyc = 0, last_t = 0, n;
	logic [15:0] rd_q[$];
	int gap_q[$];
	gtc_timer dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .ce_i(ce), .memory_mapped_config_region_addr_i(addr), .memory_mapped_config_region_wr_i(wr_s),
		.memory_mapped_config_region_rd_i(rd_s), .memory_mapped_config_region_wdata_i(wdata), .memory_mapped_config_region_rdata_o(rdata), .timer_run_i(run), .external_source_select_i(ext),
		.prescale_source_select_i(psc), .alternate_compare_select_i(alt), .continuous_select_i(cont),
		.timer2_compare_value_i(t2cmp), .timer1_input_pin_i(pin), .compare_in_use_flag_o(flag),
		.terminal_reached_o(term), .timer_run_clear_o(rclr), .timer2_terminal_o(t2term), .irq_allow_o(irq));
	always #4 clk_sys_i = ~clk_sys_i;
	function automatic logic [15:0] next_rand();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction
	task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cmp_int(input string what, input int exp, input int got);
		checks_done++;
		if (got != exp) begin
			miscompares++;
			$display("[ERR] %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task print_verdict();
		if (miscompares == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge clk_sys_i);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk_sys_i);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [15:0] exp);
		@(posedge clk_sys_i);
		addr <= a;
		rd_s <= 1'b1;
		rd_q.push_back(exp);
		@(posedge clk_sys_i);
		rd_s <= 1'b0;
	endtask
	task automatic gaps(input int ga, input int gb);
		#1;
		gap_q.push_back(ga);
		gap_q.push_back(gb);
		repeat (2) @(posedge clk_sys_i iff term === 1'b1);
	endtask
	// Result watcher and cycle ceiling
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc > 20000) begin
			miscompares++;
			print_verdict();
		end
		if (rd_seen) cmp16("read data", rd_q.pop_front(), rdata);
		rd_seen <= rd_s;
		if (term === 1'b1) begin
			if (gap_q.size() != 0) cmp_int("terminal gap", gap_q.pop_front(), cyc - last_t);
			last_t = cyc;
		end
	end
	// External pin, one rising edge every eight cycles
	always @(posedge clk_sys_i) begin
		pdiv <= pdiv + 2'b01;
		if (ext && pdiv == 2'b11) pin <= ~pin;
	end
	initial begin
		repeat (2) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		for (int i = 0; i < 4; i++) rd(GTC_T1_COUNT_OFS + 12'(2 * i), GTC_RESET_VALUE);
		for (int i = 0; i < 4; i++) begin
			v = next_rand();
			wr(i[0] ? GTC_T1_CMPB_OFS : GTC_T1_CMPA_OFS, v);
			rd(i[0] ? GTC_T1_CMPB_OFS : GTC_T1_CMPA_OFS, v);
		end
		wr(12'h000, 16'h5a5a);
		rd(12'h000, 16'h0000);
		ce <= 1'b0;
		wr(GTC_T1_CMPB_OFS, 16'h1111);
		ce <= 1'b1;
		rd(GTC_T1_CMPB_OFS, v);
		wr(GTC_T1_COUNT_OFS, 16'h1234);
		rd(GTC_T1_COUNT_OFS, 16'h1234);
		t2cmp <= 16'h0010;
		wr(GTC_T2_CTRL_OFS, 16'h6001);
		rd(GTC_T2_CTRL_OFS, 16'h2001);
		wr(GTC_T2_CTRL_OFS, 16'hc001);
		rd(GTC_T2_CTRL_OFS, 16'h8001);
		wr(GTC_T2_CTRL_OFS, 16'h0001);
		rd(GTC_T2_CTRL_OFS, 16'h8001);
		wr(GTC_T1_CMPA_OFS, 16'h0005);
		wr(GTC_T1_COUNT_OFS, 16'h0000);
		cont <= 1'b1;
		run <= 1'b1;
		@(posedge clk_sys_i iff term === 1'b1);
		gaps(20, 20);
		wr(GTC_T1_CMPA_OFS, 16'h0000);
		wr(GTC_T1_COUNT_OFS, 16'hfff0);
		n = 0;
		while (term !== 1'b1) begin
			@(posedge clk_sys_i);
			n++;
		end
		cmp_int("zero compare wait", 1, int'(n >= 57 && n <= 62));
		wr(GTC_T1_CMPA_OFS, 16'h0003);
		wr(GTC_T1_CMPB_OFS, 16'h0005);
		alt <= 1'b1;
		@(posedge clk_sys_i iff term === 1'b1 && flag === 1'b1);
		gaps(20, 12);
		cont <= 1'b0;
		@(posedge clk_sys_i iff rclr === 1'b1);
		n = 0;
		repeat (60) @(posedge clk_sys_i) if (term === 1'b1) n++;
		cmp_int("pulses after halt", 0, n);
		rd(GTC_T1_COUNT_OFS, 16'h0000);
		run <= 1'b0;
		alt <= 1'b0;
		@(posedge clk_sys_i iff t2term === 1'b1);
		t2cmp <= 16'h0002;
		psc <= 1'b1;
		cont <= 1'b1;
		wr(GTC_T1_CMPA_OFS, 16'h0003);
		run <= 1'b1;
		@(posedge clk_sys_i iff term === 1'b1);
		gaps(24, 24);
		ext <= 1'b1;
		repeat (2) @(posedge clk_sys_i iff term === 1'b1);
		gaps(24, 24);
		@(posedge clk_sys_i iff t2term === 1'b1);
		wr(GTC_T2_CTRL_OFS, 16'h4021);
		rd(GTC_T2_CTRL_OFS, 16'h0021);
		wr(GTC_T2_CTRL_OFS, 16'hc000);
		@(posedge clk_sys_i iff t2term === 1'b1);
		rd(GTC_T2_CTRL_OFS, 16'h0020);
		wr(GTC_T2_CTRL_OFS, 16'h0000);
		rd(GTC_T2_CTRL_OFS, 16'h0000);
		repeat (2) @(posedge clk_sys_i);
		print_verdict();
	end
endmodule
